// file: rtl/boost_regs_params.svh
// Purpose: offsets, field positions, reset values and timing for the
//          boost regulator register bank
// Assumes: byte-wide register port, 8-bit offsets
// Notes: definitions only
`ifndef BOOST_REGS_PARAMS_SVH
`define BOOST_REGS_PARAMS_SVH

// ==========================================================
// register offsets
`define OFS_TRIGGER_TASKS 8'h20
`define OFS_OUTPUT_LEVEL 8'h22
`define OFS_LEVEL_SOURCE 8'h23
`define OFS_BOOST_MODE 8'h24
`define OFS_COIL_PULSE_RESULT 8'h25
`define OFS_COIL_PULSE_LIMIT 8'h26
`define OFS_SMOOTH_DURATION 8'h27
`define OFS_CONTROL_PIN 8'h28
`define OFS_PIN_ACTIVE_MODE 8'h29
`define OFS_ENABLE_SET 8'h2A
`define OFS_ENABLE_CLEAR 8'h2B
`define OFS_BATT_CURRENT_LIMIT 8'h2D
`define OFS_BATT_THR_REG_EN 8'h2E
`define OFS_BATT_LOW_THR 8'h2F
`define OFS_BATT_HIGH_THR 8'h30
`define OFS_OUT_MIN_THR 8'h31
`define OFS_OUT_WARN_THR 8'h32
`define OFS_OUT_SMOOTH_THR 8'h33
`define OFS_MODE_READBACK 8'h34
`define OFS_OUTPUT_READBACK 8'h35

// ==========================================================
// field positions
`define BIT_PULSE_TRIGGER 0
`define BIT_DURATION_TRIGGER 1
`define BIT_EN_OUT_MIN 0
`define BIT_EN_OUT_WARN 1
`define BIT_EN_OUT_SMOOTH 2
`define BIT_EN_OVERCURRENT 3
`define BIT_EN_BATT_SELECT 4

// ==========================================================
// reset values
`define RST_ENABLES 5'h08
`define RST_OUT_MIN_THR 5'h0A
`define RST_OUT_WARN_THR 5'h0C
`define RST_ZERO 8'h00

// ==========================================================
// timing: base smoothing period and the millisecond tick
`define SMOOTH_BASE_PERIOD_NS 100000
`define CLK_PERIOD_NS 4
`define MS_PERIOD_NS 1000000
`define SMOOTH_BASE_CYCLES (`SMOOTH_BASE_PERIOD_NS / `CLK_PERIOD_NS)
`define MS_CYCLES (`MS_PERIOD_NS / `CLK_PERIOD_NS)

`endif

// file: rtl/boost_regs_pkg.sv
// Purpose: types shared by the boost regulator register bank
// Assumes: nothing beyond SystemVerilog packages
// Notes: encodings follow the register fields
package boost_regs_pkg;

   // ==========================================================
   // requested operating mode field
   typedef enum logic [3:0] {
      MODE_AUTO = 4'h0,
      MODE_HIGH_POWER = 4'h1,
      MODE_LOW_POWER = 4'h2,
      MODE_PASS_THROUGH = 4'h3,
      MODE_PREVENT_HIGH_POWER = 4'h4
   } boost_mode_type;

   // actual regulator mode as reported
   typedef enum logic [2:0] {
      ACT_HIGH_POWER = 3'h0,
      ACT_LOW_POWER = 3'h1,
      ACT_ULTRA_LOW_POWER = 3'h2,
      ACT_PASS_THROUGH = 3'h3,
      ACT_SMOOTHING = 3'h4
   } actual_mode_type;

   // measurement engine states
   typedef enum logic [2:0] {
      MEAS_IDLE = 3'b001,
      MEAS_PULSES = 3'b010,
      MEAS_DURATION = 3'b100
   } meas_state_type;

   // register port request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_type;

   // controls handed to the analog regulator
   typedef struct packed {
      logic [7:0] level;
      boost_mode_type mode;
      logic [1:0] smoothing;
      logic [1:0] smoothing_period;
      logic [7:0] pulse_limit;
      logic [4:0] enables;
      logic [2:0] current_limit;
      logic low_batt_reg_en;
      logic high_batt_reg_en;
      logic [5:0] batt_low_thr;
      logic [5:0] batt_high_thr;
      logic [4:0] out_min_thr;
      logic [4:0] out_warn_thr;
      logic [4:0] out_smooth_thr;
      logic batt_select_allowed;
   } boost_ctrl_type;

   // status from the analog regulator
   typedef struct packed {
      actual_mode_type mode;
      logic below_min;
      logic below_warn;
      logic coil_pulse;
      logic smoothing_active;
   } boost_stat_type;

endpackage : boost_regs_pkg

// file: rtl/boost_regulator_control_regs.sv
// Purpose: control and status register bank of the boost regulator
// Assumes: register port decoded by the serial bus engine, one access
//          per cycle, read data valid one cycle after rd
// Notes: analog behaviour lives outside; this bank produces controls
//        and captures pulse counts and smoothing durations
`timescale 1ns/1ps
`default_nettype none
`include "boost_regs_params.svh"

module boost_regulator_control_regs #(
   parameter int unsigned SMOOTH_BASE = `SMOOTH_BASE_CYCLES,
   parameter int unsigned MS_TICK = `MS_CYCLES
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire boost_regs_pkg::reg_req_type req,
   input wire logic [7:0] level_strap_pin,
   input wire logic [1:0] control_pin_in,
   input wire boost_regs_pkg::boost_stat_type stat,
   output logic [7:0] rdata,
   output boost_regs_pkg::boost_ctrl_type ctrl
);
   import boost_regs_pkg::*;

   // ==========================================================
   // stored register fields
   // only defined bits are kept
   logic [7:0] output_level_setting_reg;
   logic level_source_bit_reg;
   logic [3:0] mode_field_reg;
   logic [1:0] smoothing_reg;
   logic [1:0] smoothing_period_reg;
   logic [7:0] coil_pulse_limit_reg;
   logic [2:0] control_pin_choice_reg;
   logic [1:0] pin_active_mode_reg;
   logic [4:0] enables_reg;
   logic [2:0] battery_current_limit_reg;
   logic low_battery_reg_enable_reg;
   logic high_battery_reg_enable_reg;
   logic [5:0] battery_low_threshold_reg;
   logic [5:0] battery_high_threshold_reg;
   logic [4:0] output_min_threshold_reg;
   logic [4:0] output_warn_threshold_reg;
   logic [4:0] output_smoothing_threshold_reg;
   logic [7:0] coil_pulse_result_reg;
   logic [7:0] smoothing_duration_reg;
   logic [7:0] mode_readback_reg;
   logic [7:0] output_readback_reg;

   // rd and wr may both act
   logic wr_hit;
   logic [7:0] wd;
   assign wr_hit = req.wr;
   assign wd = req.wdata;

   // ==========================================================
   // plain read/write fields; reserved high bits are not stored
   // mode codes above 4 stored as is
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         output_level_setting_reg <= `RST_ZERO;
         level_source_bit_reg <= 1'b0;
         mode_field_reg <= 4'h0;
         smoothing_reg <= 2'h0;
         smoothing_period_reg <= 2'h0;
         coil_pulse_limit_reg <= `RST_ZERO;
         control_pin_choice_reg <= 3'h0;
         pin_active_mode_reg <= 2'h0;
      end
      else if (wr_hit)
      begin
         case (req.addr)
            `OFS_OUTPUT_LEVEL: output_level_setting_reg <= wd;
            `OFS_LEVEL_SOURCE: level_source_bit_reg <= wd[0];
            `OFS_BOOST_MODE:
            begin
               mode_field_reg <= wd[3:0];
               smoothing_reg <= wd[5:4];
               smoothing_period_reg <= wd[7:6];
            end
            `OFS_COIL_PULSE_LIMIT: coil_pulse_limit_reg <= wd;
            `OFS_CONTROL_PIN: control_pin_choice_reg <= wd[2:0];
            `OFS_PIN_ACTIVE_MODE: pin_active_mode_reg <= wd[1:0];
            default: ;
         endcase
      end
   end

   // ==========================================================
   // threshold and limit fields
   // high bits dropped, read zero
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         battery_current_limit_reg <= 3'h0;
         low_battery_reg_enable_reg <= 1'b0;
         high_battery_reg_enable_reg <= 1'b0;
         battery_low_threshold_reg <= 6'h00;
         battery_high_threshold_reg <= 6'h00;
         output_min_threshold_reg <= `RST_OUT_MIN_THR;
         output_warn_threshold_reg <= `RST_OUT_WARN_THR;
         output_smoothing_threshold_reg <= 5'h00;
      end
      else if (wr_hit)
      begin
         case (req.addr)
            `OFS_BATT_CURRENT_LIMIT: battery_current_limit_reg <= wd[2:0];
            `OFS_BATT_THR_REG_EN:
            begin
               low_battery_reg_enable_reg <= wd[0];
               high_battery_reg_enable_reg <= wd[1];
            end
            `OFS_BATT_LOW_THR: battery_low_threshold_reg <= wd[5:0];
            `OFS_BATT_HIGH_THR: battery_high_threshold_reg <= wd[5:0];
            `OFS_OUT_MIN_THR: output_min_threshold_reg <= wd[4:0];
            `OFS_OUT_WARN_THR: output_warn_threshold_reg <= wd[4:0];
            `OFS_OUT_SMOOTH_THR: output_smoothing_threshold_reg <= wd[4:0];
            default: ;
         endcase
      end
   end

   // ==========================================================
   // shared enables: set and clear registers act on one store
   // set and clear never collide
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         enables_reg <= `RST_ENABLES;
      else if (wr_hit && req.addr == `OFS_ENABLE_SET)
         enables_reg <= enables_reg | wd[4:0];
      else if (wr_hit && req.addr == `OFS_ENABLE_CLEAR)
         enables_reg <= enables_reg & ~wd[4:0];
   end

   // ==========================================================
   // effective mode: an active control pin overrides the mode field
   // reserved codes mean no pin
   logic pin_active;
   boost_mode_type mode_eff;
   always_comb
   begin
      case (control_pin_choice_reg)
         3'h1: pin_active = ~control_pin_in[0];
         3'h2: pin_active = control_pin_in[0];
         3'h3: pin_active = ~control_pin_in[1];
         3'h4: pin_active = control_pin_in[1];
         default: pin_active = 1'b0; // none or reserved codes
      endcase
      if (pin_active)
      begin
         case (pin_active_mode_reg)
            2'h0: mode_eff = MODE_HIGH_POWER;
            2'h1: mode_eff = MODE_LOW_POWER;
            2'h2: mode_eff = MODE_PASS_THROUGH;
            default: mode_eff = MODE_PREVENT_HIGH_POWER;
         endcase
      end
      else
         mode_eff = boost_mode_type'(mode_field_reg);
   end

   // smoothing is withheld unless the effective mode tolerates it;
   // this keeps the regulator safe if software breaks the pairing
   logic [1:0] smoothing_eff;
   assign smoothing_eff = (mode_eff == MODE_LOW_POWER ||
      mode_eff == MODE_PREVENT_HIGH_POWER) ? smoothing_reg : 2'h0;

   // ==========================================================
   // control outputs, all registered
   // zero for one cycle after reset
   // pulse limit enforced outside
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         ctrl <= '0;
      else
      begin
         ctrl.level <= level_source_bit_reg ? output_level_setting_reg
            : level_strap_pin;
         ctrl.mode <= mode_eff;
         ctrl.smoothing <= smoothing_eff;
         ctrl.smoothing_period <= smoothing_period_reg;
         ctrl.pulse_limit <= coil_pulse_limit_reg;
         ctrl.enables <= enables_reg;
         ctrl.current_limit <= battery_current_limit_reg;
         ctrl.low_batt_reg_en <= low_battery_reg_enable_reg;
         ctrl.high_batt_reg_en <= high_battery_reg_enable_reg;
         ctrl.batt_low_thr <= battery_low_threshold_reg;
         ctrl.batt_high_thr <= battery_high_threshold_reg;
         ctrl.out_min_thr <= output_min_threshold_reg;
         ctrl.out_warn_thr <= output_warn_threshold_reg;
         ctrl.out_smooth_thr <= output_smoothing_threshold_reg;
         ctrl.batt_select_allowed <= enables_reg[`BIT_EN_BATT_SELECT];
      end
   end

   // ==========================================================
   // task triggers: only ones start anything
   // pulse trigger wins a tie
   logic pulse_go;
   logic duration_go;
   assign pulse_go = wr_hit && req.addr == `OFS_TRIGGER_TASKS &&
      wd[`BIT_PULSE_TRIGGER];
   assign duration_go = wr_hit && req.addr == `OFS_TRIGGER_TASKS &&
      wd[`BIT_DURATION_TRIGGER];

   // refresh period length in cycles from the period code
   // code change moves the end
   logic [31:0] period_cycles;
   assign period_cycles = SMOOTH_BASE << smoothing_period_reg;

   // ==========================================================
   // measurement engine; a new trigger restarts whichever runs
   // results held until next run
   // counts saturate, never wrap
   // no ready flag is kept here
   meas_state_type meas_reg;
   logic [31:0] tick_reg;
   logic [7:0] acc_reg;
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         meas_reg <= MEAS_IDLE;
         tick_reg <= 32'h0;
         acc_reg <= 8'h00;
         coil_pulse_result_reg <= 8'h00;
         smoothing_duration_reg <= 8'h00;
      end
      else if (pulse_go)
      begin
         meas_reg <= MEAS_PULSES;
         tick_reg <= 32'h0;
         acc_reg <= 8'h00;
      end
      else if (duration_go)
      begin
         meas_reg <= MEAS_DURATION;
         tick_reg <= 32'h0;
         acc_reg <= 8'h00;
      end
      else
      begin
         case (meas_reg)
            MEAS_PULSES:
            begin
               // count pulses over one refresh period, saturating
               // last-cycle pulse counts
               if (tick_reg + 32'h1 >= period_cycles)
               begin
                  coil_pulse_result_reg <= acc_reg +
                     {7'h0, stat.coil_pulse && acc_reg != 8'hFF};
                  meas_reg <= MEAS_IDLE;
               end
               else
               begin
                  tick_reg <= tick_reg + 32'h1;
                  if (stat.coil_pulse && acc_reg != 8'hFF)
                     acc_reg <= acc_reg + 8'h01;
               end
            end
            MEAS_DURATION:
            begin
               // whole milliseconds while smoothing is active
               // partial ms dropped
               if (!stat.smoothing_active)
               begin
                  smoothing_duration_reg <= acc_reg;
                  meas_reg <= MEAS_IDLE;
               end
               else if (tick_reg + 32'h1 >= MS_TICK)
               begin
                  tick_reg <= 32'h0;
                  if (acc_reg != 8'hFF)
                     acc_reg <= acc_reg + 8'h01;
               end
               else
                  tick_reg <= tick_reg + 32'h1;
            end
            default: meas_reg <= MEAS_IDLE;
         endcase
      end
   end

   // ==========================================================
   // status capture
   // readback lags one cycle
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         mode_readback_reg <= 8'h00;
         output_readback_reg <= 8'h00;
      end
      else
      begin
         mode_readback_reg <= {5'h00, stat.mode};
         output_readback_reg <= {6'h00, stat.below_warn,
            stat.below_min};
      end
   end

   // ==========================================================
   // read mux; unmapped and write-only offsets read zero
   // rdata moves only on a read
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         rdata <= 8'h00;
      else if (req.rd)
      begin
         case (req.addr)
            `OFS_OUTPUT_LEVEL: rdata <= output_level_setting_reg;
            `OFS_LEVEL_SOURCE: rdata <= {7'h00, level_source_bit_reg};
            `OFS_BOOST_MODE: rdata <= {smoothing_period_reg,
               smoothing_reg, mode_field_reg};
            `OFS_COIL_PULSE_RESULT: rdata <= coil_pulse_result_reg;
            `OFS_COIL_PULSE_LIMIT: rdata <= coil_pulse_limit_reg;
            `OFS_SMOOTH_DURATION: rdata <= smoothing_duration_reg;
            `OFS_CONTROL_PIN: rdata <= {5'h00, control_pin_choice_reg};
            `OFS_PIN_ACTIVE_MODE: rdata <= {6'h00, pin_active_mode_reg};
            `OFS_ENABLE_SET: rdata <= {3'h0, enables_reg};
            `OFS_ENABLE_CLEAR: rdata <= {3'h0, enables_reg};
            `OFS_BATT_CURRENT_LIMIT: rdata <= {5'h00,
               battery_current_limit_reg};
            `OFS_BATT_THR_REG_EN: rdata <= {6'h00,
               high_battery_reg_enable_reg, low_battery_reg_enable_reg};
            `OFS_BATT_LOW_THR: rdata <= {2'h0, battery_low_threshold_reg};
            `OFS_BATT_HIGH_THR: rdata <= {2'h0, battery_high_threshold_reg};
            `OFS_OUT_MIN_THR: rdata <= {3'h0, output_min_threshold_reg};
            `OFS_OUT_WARN_THR: rdata <= {3'h0, output_warn_threshold_reg};
            `OFS_OUT_SMOOTH_THR: rdata <= {3'h0,
               output_smoothing_threshold_reg};
            `OFS_MODE_READBACK: rdata <= mode_readback_reg;
            `OFS_OUTPUT_READBACK: rdata <= output_readback_reg;
            default: rdata <= 8'h00;
         endcase
      end
   end

endmodule : boost_regulator_control_regs
`default_nettype wire

// file: verification/boost_regs_asserts.sv
// Purpose: port checker for the boost register bank
// Assumes: bound into the bank, one clock, synchronous reset
// Notes: enable checks skip a write followed at once by another
`timescale 1ns/1ps
`default_nettype none
`include "boost_regs_params.svh"

module boost_regs_asserts
#(
   parameter int unsigned SMOOTH_BASE = 10,
   parameter int unsigned MS_TICK = 20
)
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire boost_regs_pkg::reg_req_type req,
   input wire logic [7:0] level_strap_pin,
   input wire logic [1:0] control_pin_in,
   input wire boost_regs_pkg::boost_stat_type stat,
   input wire logic [7:0] rdata,
   input wire boost_regs_pkg::boost_ctrl_type ctrl
);
   import boost_regs_pkg::*;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);

   // ==========================================================
   // lone writes to the shared enable pair
   sequence s_set_alone;
      req.wr && req.addr == `OFS_ENABLE_SET ##1 !req.wr;
   endsequence
   sequence s_clr_alone;
      req.wr && req.addr == `OFS_ENABLE_CLEAR ##1 !req.wr;
   endsequence

   // ==========================================================
   // read path
   a_read_holds: assert property (!req.rd |=> $stable(rdata))
      else $error("read data moved without a read");
   a_hole_zero: assert property (
      req.rd && !req.wr && (req.addr == 8'h20 || req.addr == 8'h21
      || req.addr == 8'h2C || req.addr > 8'h35) |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   // readback adds a stage: stat from two cycles back
   a_mode_readback: assert property (
      req.rd && req.addr == 8'h34
      |=> rdata == {5'h00, $past(stat.mode, 2)})
      else $error("mode readback wrong");
   a_out_readback: assert property (
      req.rd && req.addr == 8'h35 |=> rdata[1:0]
      == {$past(stat.below_warn, 2), $past(stat.below_min, 2)})
      else $error("output readback wrong");

   // ==========================================================
   // control outputs; written values land two cycles on
   a_enable_set: assert property (s_set_alone
      |=> (ctrl.enables & $past(req.wdata[4:0], 2))
      == $past(req.wdata[4:0], 2))
      else $error("set write did not enable");
   a_enable_clear: assert property (s_clr_alone
      |=> (ctrl.enables & $past(req.wdata[4:0], 2)) == 5'h00)
      else $error("clear write did not disable");
   a_smooth_gate: assert property (ctrl.smoothing != 2'h0
      |-> ctrl.mode == MODE_LOW_POWER
      || ctrl.mode == MODE_PREVENT_HIGH_POWER)
      else $error("smoothing passed in wrong mode");
   a_batt_select: assert property (ctrl.batt_select_allowed
      == ctrl.enables[`BIT_EN_BATT_SELECT])
      else $error("battery select allow differs from enable");
   a_min_thr_write: assert property (req.wr && req.addr == 8'h31
      |-> ##2 ctrl.out_min_thr == $past(req.wdata[4:0], 2))
      else $error("minimum threshold not applied");

endmodule : boost_regs_asserts
`default_nettype wire

// file: verification/reg_host_model.sv
// Purpose: host side of the register port
// Assumes: strobes taken on the rising edge, read data a cycle later
// Notes: one idle cycle between accesses keeps drivers race free
`timescale 1ns/1ps
`default_nettype none

module reg_host_model
(
   input wire logic mclk,
   input wire logic [7:0] rdata,
   output var boost_regs_pkg::reg_req_type req
);
   import boost_regs_pkg::*;

   // idle port from time zero
   initial req = '0;

   // ==========================================================
   // one write, strobe up for exactly one taking edge
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge mclk);
      req <= '0;
   endtask : write_reg

   // one read, data sampled after it has settled
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge mclk);
      req <= '0;
      @(posedge mclk);
      d = rdata;
   endtask : read_reg

endmodule : reg_host_model
`default_nettype wire

// file: verification/boost_regulator_control_regs_tb_top.sv
// Purpose: self-checking bench for the boost register bank
// Assumes: short smoothing base and millisecond tick
// Notes: bench drives strap, pins and status; host model the port
`timescale 1ns/1ps
`default_nettype none
`include "boost_regs_params.svh"

module boost_regulator_control_regs_tb_top;
   import boost_regs_pkg::*;
   localparam int unsigned SB = 10;
   localparam int unsigned MT = 20;
   logic mclk;
   logic sys_rst;
   reg_req_type req;
   logic [7:0] level_strap_pin;
   logic [1:0] control_pin_in;
   boost_stat_type stat;
   logic [7:0] rdata;
   boost_ctrl_type ctrl;
   logic [7:0] rd_val;
   int failures;
   int total_checks;
   // offsets, reset values, readback after writing all ones
   logic [7:0] ofs [17] = '{8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27,
      8'h28, 8'h29, 8'h2A, 8'h2B, 8'h2D, 8'h2E, 8'h2F, 8'h30, 8'h31,
      8'h32, 8'h33};
   logic [7:0] rst [17] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h08, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0A,
      8'h0C, 8'h00};
   logic [7:0] ones [17] = '{8'hFF, 8'h01, 8'hFF, 8'h00, 8'hFF, 8'h00,
      8'h07, 8'h03, 8'h1F, 8'h00, 8'h07, 8'h03, 8'h3F, 8'h3F, 8'h1F,
      8'h1F, 8'h1F};

   boost_regulator_control_regs #(.SMOOTH_BASE(SB), .MS_TICK(MT))
   u_boost_regulator_control_regs (.mclk(mclk), .sys_rst(sys_rst),
      .req(req), .level_strap_pin(level_strap_pin),
      .control_pin_in(control_pin_in), .stat(stat), .rdata(rdata),
      .ctrl(ctrl));
   reg_host_model u_reg_host_model (.mclk(mclk), .rdata(rdata),
      .req(req));

   // ==========================================================
   // clock, watchdog
   initial
   begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   initial
   begin
      repeat (60000) @(posedge mclk);
      failures++;
      give_verdict();
   end

   // ==========================================================
   // helpers
   task automatic give_verdict();
      if (failures == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : give_verdict
   task automatic check(string what, logic [7:0] e, logic [7:0] g);
      total_checks++;
      if (g !== e)
      begin
         failures++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask : check
   task automatic rd_check(logic [7:0] a, logic [7:0] e, logic [7:0] m);
      u_reg_host_model.read_reg(a, rd_val);
      check($sformatf("reg %h", a), e, rd_val & m);
   endtask : rd_check
   task automatic wr(logic [7:0] a, logic [7:0] d);
      u_reg_host_model.write_reg(a, d);
   endtask : wr
   // ctrl is registered twice behind a write, once behind a pin change
   task automatic settle();
      repeat (3) @(posedge mclk);
   endtask : settle
   task automatic do_reset();
      @(posedge mclk);
      sys_rst <= 1'b1;
      repeat (4) @(posedge mclk);
      sys_rst <= 1'b0;
   endtask : do_reset
   task automatic pulses(int n);
      repeat (n)
      begin
         @(posedge mclk);
         stat.coil_pulse <= 1'b1;
         @(posedge mclk);
         stat.coil_pulse <= 1'b0;
      end
   endtask : pulses

   // ==========================================================
   // scenarios
   task automatic t_reset_values();
      for (int i = 0; i < 17; i++)
         rd_check(ofs[i], rst[i], 8'hFF);
      rd_check(8'h20, 8'h00, 8'hFF);
      rd_check(8'h2C, 8'h00, 8'hFF);
      check("strap level", level_strap_pin, ctrl.level);
   endtask : t_reset_values
   // all ones into every offset in the table; read-only ones stay zero
   task automatic t_fields();
      for (int i = 0; i < 17; i++)
      begin
         wr(ofs[i], 8'hFF);
         rd_check(ofs[i], ones[i], 8'hFF);
      end
      settle();
      check("level", 8'hFF, ctrl.level);
      check("pulse limit", 8'hFF, ctrl.pulse_limit);
      check("current limit", 8'h07, {5'h00, ctrl.current_limit});
      check("batt low", 8'h3F, {2'h0, ctrl.batt_low_thr});
      check("batt high", 8'h3F, {2'h0, ctrl.batt_high_thr});
      check("batt en", 8'h03,
         {6'h00, ctrl.high_batt_reg_en, ctrl.low_batt_reg_en});
      check("smooth thr", 8'h1F, {3'h0, ctrl.out_smooth_thr});
      check("warn thr", 8'h1F, {3'h0, ctrl.out_warn_thr});
      check("sel off", 8'h00, {7'h00, ctrl.batt_select_allowed});
   endtask : t_fields
   task automatic t_enables();
      wr(8'h2A, 8'h15);
      rd_check(8'h2A, 8'h1D, 8'hFF);
      rd_check(8'h2B, 8'h1D, 8'hFF);
      wr(8'h2B, 8'h0C);
      wr(8'h2A, 8'h00);
      wr(8'h2B, 8'h00);
      rd_check(8'h2B, 8'h11, 8'hFF);
      settle();
      check("enables", 8'h11, {3'h0, ctrl.enables});
      check("sel on", 8'h01, {7'h00, ctrl.batt_select_allowed});
   endtask : t_enables
   task automatic t_level_source();
      wr(8'h22, 8'h1E);
      wr(8'h23, 8'h00);
      level_strap_pin <= 8'h05;
      settle();
      check("strap level", 8'h05, ctrl.level);
      wr(8'h23, 8'h01);
      settle();
      check("reg level", 8'h1E, ctrl.level);
   endtask : t_level_source
   task automatic t_modes();
      logic [1:0] sm;
      for (int m = 0; m < 5; m++)
      begin
         sm = m[1] ? 2'h2 : 2'h1;
         wr(8'h24, {2'h2, sm, m[3:0]});
         settle();
         check("mode", 8'(m), {4'h0, ctrl.mode});
         check("smooth", (m == 2 || m == 4) ? 8'(sm) : 8'h00,
            {6'h00, ctrl.smoothing});
         check("period", 8'h02, {6'h00, ctrl.smoothing_period});
      end
   endtask : t_modes
   // other pin sits at a level that would count as active
   task automatic t_pin_override();
      logic hi;
      logic sel;
      wr(8'h24, 8'h00);
      for (int c = 1; c < 6; c++)
      begin
         hi = (c % 2 == 0);
         sel = (c > 2);
         wr(8'h28, 8'(c));
         wr(8'h29, 8'((c - 1) % 4));
         control_pin_in <= sel ? {!hi, hi} : {hi, !hi};
         settle();
         check("pin idle", 8'h00, {4'h0, ctrl.mode});
         control_pin_in <= {hi, hi};
         settle();
         check("pin mode", (c < 5) ? 8'(c) : 8'h00,
            {4'h0, ctrl.mode});
      end
      control_pin_in <= 2'b00;
      wr(8'h28, 8'h00);
   endtask : t_pin_override
   task automatic t_pulse_count();
      wr(8'h24, 8'h40);
      wr(8'h20, 8'h01);
      pulses(6);
      repeat (3 * SB) @(posedge mclk);
      pulses(1);
      rd_check(8'h25, 8'h06, 8'hFF);
      wr(8'h20, 8'h00);
      pulses(2);
      repeat (3 * SB) @(posedge mclk);
      rd_check(8'h25, 8'h06, 8'hFF);
   endtask : t_pulse_count
   task automatic t_duration();
      wr(8'h20, 8'h02);
      stat.smoothing_active <= 1'b1;
      repeat (5 * MT + MT / 2) @(posedge mclk);
      stat.smoothing_active <= 1'b0;
      repeat (5) @(posedge mclk);
      rd_check(8'h27, 8'h05, 8'hFF);
      wr(8'h20, 8'h00);
      stat.smoothing_active <= 1'b1;
      repeat (3 * MT) @(posedge mclk);
      stat.smoothing_active <= 1'b0;
      rd_check(8'h27, 8'h05, 8'hFF);
   endtask : t_duration
   task automatic t_status();
      for (int m = 0; m < 5; m++)
      begin
         stat.mode <= actual_mode_type'(m[2:0]);
         stat.below_min <= m[0];
         stat.below_warn <= m[1];
         rd_check(8'h34, 8'(m), 8'hFF);
         rd_check(8'h35, {6'h00, m[1:0]}, 8'h03);
      end
   endtask : t_status

   // ==========================================================
   // main sequence
   initial
   begin
      sys_rst = 1'b1;
      level_strap_pin = 8'h0B;
      control_pin_in = 2'b00;
      stat = '0;
      failures = 0;
      total_checks = 0;
      repeat (4) @(posedge mclk);
      sys_rst <= 1'b0;
      t_reset_values();
      t_fields();
      do_reset();
      t_reset_values();
      t_enables();
      t_level_source();
      t_modes();
      t_pin_override();
      t_pulse_count();
      t_duration();
      t_status();
      give_verdict();
   end

endmodule : boost_regulator_control_regs_tb_top

bind boost_regulator_control_regs boost_regs_asserts
#(.SMOOTH_BASE(SMOOTH_BASE), .MS_TICK(MS_TICK)) u_boost_regs_asserts (
   .mclk(mclk), .sys_rst(sys_rst), .req(req),
   .level_strap_pin(level_strap_pin), .control_pin_in(control_pin_in),
   .stat(stat), .rdata(rdata), .ctrl(ctrl));
`default_nettype wire
